// >>> verilog/brd_pkg.sv
package brd_pkg;
  // Byte offsets of the register words
  localparam logic [5:0] OFS_LAMP = 6'h00;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h04;
  localparam logic [5:0] OFS_CACHE = 6'h08;
  localparam logic [5:0] OFS_XLATE = 6'h0C;
  localparam logic [5:0] OFS_MEM = 6'h10;
  localparam logic [5:0] OFS_WDOG = 6'h14;
  localparam logic [5:0] OFS_SERIAL = 6'h18;
  localparam logic [5:0] OFS_BOOT = 6'h1C;
  localparam logic [5:0] OFS_VSLAVE = 6'h20;
  localparam logic [5:0] OFS_VMASTER = 6'h24;
  localparam logic [5:0] OFS_VINTR = 6'h28;
  localparam logic [5:0] OFS_SYSCTL = 6'h2C;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h30;
  localparam logic [5:0] OFS_CMD = 6'h34;
  // Field positions
  localparam int CACHE_D_BIT = 31;
  localparam int CACHE_I_BIT = 15;
  localparam int XLATE_EN_BIT = 15;
  localparam int EVT_ABORT = 0;
  localparam int EVT_PARITY = 1;
  localparam int EVT_SYSFAIL = 2;
  // Reset values
  localparam logic [7:0] LAMP_APP_RST = 8'hFF;
  localparam logic LAMP_FAIL_RST = 1'b1;
  localparam logic [2:0] IRQ_MASK_RST = 3'h1;
  localparam logic [31:0] CACHE_RST = 32'h0000_0000;
  localparam logic [31:0] XLATE_RST = 32'h0000_0000;
  localparam logic [1:0] WDOG_RST = 2'h0;
  localparam logic [1:0] SERIAL_RST = 2'h0;
  localparam logic BOOT_RST = 1'b1;
  localparam logic [1:0] VSL_A32 = 2'h2;
  localparam logic [2:0] VSL_WIN_16MB = 3'h4;
  localparam logic [1:0] VMST_LEVEL_RST = 2'h3;
  localparam logic [2:0] VINTR_LEVEL_RST = 3'h7;
  localparam logic [7:0] VINTR_VEC_RST = 8'h00;
  localparam logic [6:0] VHND_RST = 7'h00;
  // VMEbus slave window settings
  typedef struct packed {
    logic [7:0] base;
    logic upper_range;
    logic [2:0] win_size;
    logic [1:0] addr_width;
    logic user_write;
    logic write_en;
    logic enable;
  } brd_vslave_t;
  localparam brd_vslave_t VSLAVE_RST = '{base: 8'h00, upper_range: 1'b0,
    win_size: VSL_WIN_16MB, addr_width: VSL_A32, user_write: 1'b0,
    write_en: 1'b0, enable: 1'b0};
  // VMEbus master and interrupter settings
  typedef struct packed {
    logic [1:0] level;
    logic fair;
    logic release_any;
  } brd_vmaster_t;
  localparam brd_vmaster_t VMASTER_RST = '{level: VMST_LEVEL_RST, fair: 1'b0,
    release_any: 1'b0};
  typedef struct packed {
    logic [6:0] handler_en;
    logic [7:0] vector;
    logic [2:0] level;
    logic run;
  } brd_vintr_t;
  localparam brd_vintr_t VINTR_RST = '{handler_en: VHND_RST, vector: VINTR_VEC_RST,
    level: VINTR_LEVEL_RST, run: 1'b0};
endpackage : brd_pkg

// >>> verilog/brd_defaults.sv
// Chosen here: the register offsets and the Avalon-MM register port.
module brd_defaults
  import brd_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic ABORT_SW,
  input wire logic PARITY_ERR,
  input wire logic SYSFAIL_IN,
  input wire logic SYSRESET_IN,
  input wire logic JUMPER_FITTED,
  input wire logic [1:0] JUMPER_LEVEL,
  output logic [7:0] APP_LAMP,
  output logic FAIL_LAMP,
  output logic IRQ,
  output logic DCACHE_EN,
  output logic ICACHE_EN,
  output logic CACHE_INVALIDATE,
  output logic [31:0] XLATE_WORD,
  output logic PARITY_CHK_EN,
  output logic WDOG_HALT_EN,
  output logic WDOG_RUN_EN,
  output logic SER2_DRV_EN,
  output logic SER4_DRV_EN,
  output logic BOOT_ROM2_CPU2_EN,
  output brd_vslave_t VSLAVE_CFG,
  output logic VME_RELEASE_ANY,
  output logic VME_FAIR_REQ,
  output logic [1:0] VME_REQ_LEVEL,
  output brd_vintr_t VINTR_CFG,
  output logic SYSFAIL_DRV,
  output logic BOARD_RESET_REQ
);

  logic rst_meta_r; // First reset stage
  logic rst_n; // Synchronised reset
  logic wait_r; // Bus wait state
  logic [31:0] rdata_r; // Read data
  logic [31:0] rd_nxt; // Read mux
  logic acc; // Access completes this edge
  logic wr; // Completing write
  logic rd; // Completing read
  logic srst_r; // Board reset from backplane
  logic [8:0] lamp_r; // Fail lamp and app lamps
  logic [2:0] msk_r; // Interrupt mask
  logic [31:0] cache_r; // Cache control word
  logic inval_r; // Cache invalidate pulse
  logic [31:0] xlate_r; // Translation window word
  logic par_en_r; // Parity checking
  logic [1:0] wdog_r; // Watchdog monitors
  logic [1:0] ser_r; // Serial driver enables
  logic boot_r; // Second boot ROM access
  brd_vslave_t vsl_r; // Slave window
  brd_vmaster_t vms_r; // Master settings
  brd_vintr_t vin_r; // Interrupter settings
  logic [1:0] req_lvl_r; // Effective request level
  logic sres_ign_r; // Ignore backplane reset
  logic sfail_rel_r; // Failure line released
  logic sfail_rx_r; // Failure reception enable
  logic [2:0] st_r; // Sticky event status
  logic [2:0] st_nxt; // Next status
  logic [2:0] ev; // Events this cycle
  logic abort_d_r; // Abort switch delayed
  logic irq_r; // Interrupt output
  logic [31:0] lamp_m; // Lamp word after byte-lane merge
  logic [31:0] vsl_m; // Slave word after byte-lane merge
  logic [31:0] vin_m; // Interrupter word after byte-lane merge

  // Byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (AVS_BYTEENABLE[i]) begin
        res[i*8 +: 8] = AVS_WRITEDATA[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Merged words for the narrow registers; a process so lane changes are seen
  always_comb begin
    lamp_m = merge({23'h0, lamp_r});
    vsl_m = merge({15'h0, vsl_r});
    vin_m = merge({13'h0, vin_r});
  end

  // Reset release through two flip-flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // One wait cycle, then the access completes
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
    end else if ((AVS_READ || AVS_WRITE) && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  assign acc = (AVS_READ || AVS_WRITE) && !wait_r;
  assign wr = acc && AVS_WRITE;
  assign rd = acc && AVS_READ;

  // Backplane reset, honoured unless software chose to ignore it
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      srst_r <= 1'b0;
    end else begin
      srst_r <= SYSRESET_IN && !sres_ign_r;
    end
  end

  // Lamps: all on after reset
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      lamp_r <= {LAMP_FAIL_RST, LAMP_APP_RST};
    end else if (srst_r) begin
      lamp_r <= {LAMP_FAIL_RST, LAMP_APP_RST};
    end else if (wr && AVS_ADDRESS == OFS_LAMP) begin
      lamp_r <= lamp_m[8:0];
    end
  end

  // Interrupt mask; abort bit cannot be cleared
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      msk_r <= IRQ_MASK_RST;
    end else if (srst_r) begin
      msk_r <= IRQ_MASK_RST;
    end else if (wr && AVS_ADDRESS == OFS_IRQ_MASK) begin
      msk_r <= {AVS_WRITEDATA[2:1], 1'b1};
    end
  end

  // Cache word: only a full-word write takes; reset clears it
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cache_r <= CACHE_RST;
    end else if (srst_r) begin
      cache_r <= CACHE_RST;
    end else if (wr && AVS_ADDRESS == OFS_CACHE && AVS_BYTEENABLE == 4'hF) begin
      cache_r <= AVS_WRITEDATA;
    end
  end

  // Invalidate only on software command, never on reset
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      inval_r <= 1'b0;
    end else begin
      inval_r <= wr && AVS_ADDRESS == OFS_CMD && AVS_WRITEDATA[0] && !srst_r;
    end
  end

  // Translation window: base, mask, enable/modes, attributes
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      xlate_r <= XLATE_RST;
    end else if (srst_r) begin
      xlate_r <= XLATE_RST;
    end else if (wr && AVS_ADDRESS == OFS_XLATE) begin
      xlate_r <= merge(xlate_r);
    end
  end

  // Parity, watchdog, serial, boot ROM controls
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      par_en_r <= 1'b0;
      wdog_r <= WDOG_RST;
      ser_r <= SERIAL_RST;
      boot_r <= BOOT_RST;
    end else if (srst_r) begin
      par_en_r <= 1'b0;
      wdog_r <= WDOG_RST;
      ser_r <= SERIAL_RST;
      boot_r <= BOOT_RST;
    end else if (wr) begin
      // Byte 0 carries these controls
      if (AVS_ADDRESS == OFS_MEM && AVS_BYTEENABLE[0]) begin
        par_en_r <= AVS_WRITEDATA[0];
      end
      if (AVS_ADDRESS == OFS_WDOG && AVS_BYTEENABLE[0]) begin
        wdog_r <= AVS_WRITEDATA[1:0];
      end
      if (AVS_ADDRESS == OFS_SERIAL && AVS_BYTEENABLE[0]) begin
        ser_r <= AVS_WRITEDATA[1:0];
      end
      if (AVS_ADDRESS == OFS_BOOT && AVS_BYTEENABLE[0]) begin
        boot_r <= AVS_WRITEDATA[0];
      end
    end
  end

  // VMEbus slave window
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      vsl_r <= VSLAVE_RST;
    end else if (srst_r) begin
      vsl_r <= VSLAVE_RST;
    end else if (wr && AVS_ADDRESS == OFS_VSLAVE) begin
      vsl_r <= vsl_m[16:0];
    end
  end

  // VMEbus master; a fitted jumper overrides the level
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      vms_r <= VMASTER_RST;
    end else if (srst_r) begin
      vms_r <= VMASTER_RST;
    end else if (wr && AVS_ADDRESS == OFS_VMASTER && AVS_BYTEENABLE[0]) begin
      vms_r <= AVS_WRITEDATA[3:0];
    end
  end

  // Effective request level
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      req_lvl_r <= VMST_LEVEL_RST;
    end else if (JUMPER_FITTED) begin
      req_lvl_r <= JUMPER_LEVEL;
    end else begin
      req_lvl_r <= vms_r.level;
    end
  end

  // VMEbus interrupter and handler levels
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      vin_r <= VINTR_RST;
    end else if (srst_r) begin
      vin_r <= VINTR_RST;
    end else if (wr && AVS_ADDRESS == OFS_VINTR) begin
      vin_r <= vin_m[18:0];
    end
  end

  // System line controls
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sres_ign_r <= 1'b0;
      sfail_rel_r <= 1'b0;
      sfail_rx_r <= 1'b0;
    end else if (srst_r) begin
      sres_ign_r <= 1'b0;
      sfail_rel_r <= 1'b0;
      sfail_rx_r <= 1'b0;
    end else if (wr && AVS_ADDRESS == OFS_SYSCTL && AVS_BYTEENABLE[0]) begin
      sres_ign_r <= AVS_WRITEDATA[0];
      sfail_rel_r <= AVS_WRITEDATA[1];
      sfail_rx_r <= AVS_WRITEDATA[2];
    end
  end

  // Abort switch edge detect
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      abort_d_r <= 1'b0;
    end else begin
      abort_d_r <= ABORT_SW;
    end
  end

  // Events; parity and failure reception gated by their enables
  always_comb begin
    ev = 3'h0;
    ev[EVT_ABORT] = ABORT_SW && !abort_d_r;
    ev[EVT_PARITY] = PARITY_ERR && par_en_r;
    ev[EVT_SYSFAIL] = SYSFAIL_IN && sfail_rx_r;
    // Read clears only the bits it reported, a new event wins
    st_nxt = st_r;
    if (rd && AVS_ADDRESS == OFS_IRQ_STAT) begin
      st_nxt = st_r & ~rdata_r[2:0];
    end
    st_nxt = st_nxt | ev;
  end

  // Sticky status and interrupt level
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= 3'h0;
      irq_r <= 1'b0;
    end else if (srst_r) begin
      st_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      irq_r <= |(st_nxt & msk_r);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h0;
    unique case (AVS_ADDRESS)
      OFS_LAMP: rd_nxt = {23'h0, lamp_r};
      OFS_IRQ_MASK: rd_nxt = {29'h0, msk_r};
      OFS_CACHE: rd_nxt = cache_r;
      OFS_XLATE: rd_nxt = xlate_r;
      OFS_MEM: rd_nxt = {31'h0, par_en_r};
      OFS_WDOG: rd_nxt = {30'h0, wdog_r};
      OFS_SERIAL: rd_nxt = {30'h0, ser_r};
      OFS_BOOT: rd_nxt = {31'h0, boot_r};
      OFS_VSLAVE: rd_nxt = {15'h0, vsl_r};
      OFS_VMASTER: rd_nxt = {26'h0, req_lvl_r, vms_r};
      OFS_VINTR: rd_nxt = {13'h0, vin_r};
      OFS_SYSCTL: rd_nxt = {29'h0, sfail_rx_r, sfail_rel_r, sres_ign_r};
      OFS_IRQ_STAT: rd_nxt = {29'h0, st_r};
      default: rd_nxt = 32'h0;
    endcase
  end

  // Read data captured as the wait ends
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (AVS_READ && wait_r) begin
      rdata_r <= rd_nxt;
    end
  end

  // Outputs straight from flip-flops; SYSFAIL_DRV through an inverter on sfail_rel_r
  assign AVS_READDATA = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign APP_LAMP = lamp_r[7:0];
  assign FAIL_LAMP = lamp_r[8];
  assign IRQ = irq_r;
  assign DCACHE_EN = cache_r[CACHE_D_BIT];
  assign ICACHE_EN = cache_r[CACHE_I_BIT];
  assign CACHE_INVALIDATE = inval_r;
  assign XLATE_WORD = xlate_r;
  assign PARITY_CHK_EN = par_en_r;
  assign WDOG_HALT_EN = wdog_r[0];
  assign WDOG_RUN_EN = wdog_r[1];
  assign SER2_DRV_EN = ser_r[0];
  assign SER4_DRV_EN = ser_r[1];
  assign BOOT_ROM2_CPU2_EN = boot_r;
  assign VSLAVE_CFG = vsl_r;
  assign VME_RELEASE_ANY = vms_r.release_any;
  assign VME_FAIR_REQ = vms_r.fair;
  assign VME_REQ_LEVEL = req_lvl_r;
  assign VINTR_CFG = vin_r;
  assign SYSFAIL_DRV = !sfail_rel_r;
  assign BOARD_RESET_REQ = srst_r;

  // Lamps lit at the first cycle out of reset
  property p_lamp_rst;
    @(posedge CORE_CLK) $rose(rst_n) |-> APP_LAMP == LAMP_APP_RST && FAIL_LAMP;
  endproperty
  a_lamp_rst: assert property (p_lamp_rst) else $error("lamps not on after reset");

  // Abort raises the interrupt one edge later unless a board reset is active
  property p_abort;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (ABORT_SW && !abort_d_r && !srst_r) |=> ##0 IRQ;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not interrupt");

  // No parity event while checking is off
  property p_parity_off;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (!par_en_r && !st_r[EVT_PARITY]) |=> !st_r[EVT_PARITY];
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("parity event while off");

  // Partial writes leave the cache word alone
  property p_cache_whole;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (wr && AVS_ADDRESS == OFS_CACHE && AVS_BYTEENABLE != 4'hF && !srst_r)
      |=> $stable(cache_r);
  endproperty
  a_cache_whole: assert property (p_cache_whole) else $error("partial cache write");

  // Board reset disables caches without invalidating
  property p_cache_rst;
    @(posedge CORE_CLK) disable iff (!rst_n)
      srst_r |=> !DCACHE_EN && !ICACHE_EN && !CACHE_INVALIDATE;
  endproperty
  a_cache_rst: assert property (p_cache_rst) else $error("cache reset state wrong");

  // Board reset leaves no translation window
  property p_xlate_rst;
    @(posedge CORE_CLK) disable iff (!rst_n) srst_r |=> XLATE_WORD == XLATE_RST;
  endproperty
  a_xlate_rst: assert property (p_xlate_rst) else $error("translation not cleared");

  // Backplane reset reaches defaults in two cycles
  property p_sysres;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (SYSRESET_IN && !sres_ign_r) |=> BOARD_RESET_REQ ##1 (SYSFAIL_DRV && !SER2_DRV_EN
      && !SER4_DRV_EN && VSLAVE_CFG == VSLAVE_RST);
  endproperty
  a_sysres: assert property (p_sysres) else $error("backplane reset ignored");

  // Failure line driven after board reset
  property p_sysfail;
    @(posedge CORE_CLK) disable iff (!rst_n)
      srst_r |=> SYSFAIL_DRV && !sfail_rx_r && !WDOG_HALT_EN && !WDOG_RUN_EN;
  endproperty
  a_sysfail: assert property (p_sysfail) else $error("failure line not driven");

  // Request level follows software setting without jumper
  property p_req_lvl;
    @(posedge CORE_CLK) disable iff (!rst_n)
      !JUMPER_FITTED |=> VME_REQ_LEVEL == $past(vms_r.level);
  endproperty
  a_req_lvl: assert property (p_req_lvl) else $error("request level wrong");

  // Interrupter held after board reset
  property p_vintr;
    @(posedge CORE_CLK) disable iff (!rst_n)
      srst_r |=> !VINTR_CFG.run && VINTR_CFG.level == VINTR_LEVEL_RST
      && VINTR_CFG.handler_en == VHND_RST && BOOT_ROM2_CPU2_EN;
  endproperty
  a_vintr: assert property (p_vintr) else $error("interrupter not held");

endmodule : brd_defaults

// >>> testbench/brd_backplane.sv
module brd_backplane (
  input wire logic clk,
  input wire logic sysfail_drv,
  output logic abort_sw,
  output logic parity_err,
  output logic sysfail_in,
  output logic sysreset_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Another board pulling the shared failure line
  logic other_fail;
  // Wired failure line: any board asserting it holds it asserted
  assign sysfail_in = sysfail_drv | other_fail;
  // Quiet backplane at time zero
  initial begin
    abort_sw = 1'b0;
    parity_err = 1'b0;
    sysreset_in = 1'b0;
    other_fail = 1'b0;
  end
  // One-cycle event: 0 abort switch, 1 parity fault, 2 system reset
  task pulse(input int which);
    @(posedge clk);
    case (which)
      0: abort_sw <= 1'b1;
      1: parity_err <= 1'b1;
      default: sysreset_in <= 1'b1;
    endcase
    @(posedge clk);
    abort_sw <= 1'b0;
    parity_err <= 1'b0;
    sysreset_in <= 1'b0;
  endtask : pulse
  // Another board asserting or releasing the failure line
  task hold_fail(input logic v);
    other_fail <= v;
  endtask : hold_fail
endmodule : brd_backplane

// >>> testbench/brd_defaults_bench.sv
module brd_defaults_bench;
  import brd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic abort_sw, parity_err, sysfail_in, sysreset_in;
  logic jumper_fitted = 1'b0;
  logic [1:0] jumper_level = 2'h0;
  logic [7:0] app_lamp;
  logic fail_lamp, irq, dcache_en, icache_en, cache_inv, parity_en, wd_halt, wd_run;
  logic ser2_en, ser4_en, boot2_en, rel_any, fair_req, sysfail_drv, brd_rst_req;
  logic [1:0] req_level;
  logic [31:0] xlate_word;
  brd_vslave_t vslave_cfg;
  brd_vintr_t vintr_cfg;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int n_rst = 0;
  int n_inv = 0;
  logic [5:0] ofs [12] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C,
    6'h20, 6'h24, 6'h28, 6'h2C};
  logic [31:0] dflt [12] = '{32'h1FF, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1,
    32'h90, 32'h3C, 32'hE, 32'h0};
  // 10 MHz core clock
  always #50 core_clk = ~core_clk;
  brd_defaults i_brd_defaults (.CORE_CLK(core_clk), .RESETN(rst_n),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .ABORT_SW(abort_sw), .PARITY_ERR(parity_err), .SYSFAIL_IN(sysfail_in),
    .SYSRESET_IN(sysreset_in), .JUMPER_FITTED(jumper_fitted), .JUMPER_LEVEL(jumper_level),
    .APP_LAMP(app_lamp), .FAIL_LAMP(fail_lamp), .IRQ(irq), .DCACHE_EN(dcache_en),
    .ICACHE_EN(icache_en), .CACHE_INVALIDATE(cache_inv), .XLATE_WORD(xlate_word),
    .PARITY_CHK_EN(parity_en), .WDOG_HALT_EN(wd_halt), .WDOG_RUN_EN(wd_run),
    .SER2_DRV_EN(ser2_en), .SER4_DRV_EN(ser4_en), .BOOT_ROM2_CPU2_EN(boot2_en),
    .VSLAVE_CFG(vslave_cfg), .VME_RELEASE_ANY(rel_any), .VME_FAIR_REQ(fair_req),
    .VME_REQ_LEVEL(req_level), .VINTR_CFG(vintr_cfg), .SYSFAIL_DRV(sysfail_drv),
    .BOARD_RESET_REQ(brd_rst_req));
  brd_backplane i_brd_backplane (.clk(core_clk), .sysfail_drv(sysfail_drv),
    .abort_sw(abort_sw), .parity_err(parity_err), .sysfail_in(sysfail_in),
    .sysreset_in(sysreset_in));
  // Verdict and end of run
  task finish_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // Cycle count, pulse counters and hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (brd_rst_req === 1'b1) n_rst++;
    if (cache_inv === 1'b1) n_inv++;
    if (cycles > 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // Compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus access, held until waitrequest is sampled low
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) n_mismatch++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // Write with chosen lanes
  task wrb(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask : wrb
  // Full-word write
  task wr(input logic [5:0] a, input logic [31:0] d);
    wrb(a, d, 4'hF);
  endtask : wr
  // Read and compare
  task rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(q, exp);
  endtask : rd
  // Idle cycles
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Default state of the level outputs other than IRQ and of the registers at offsets 0x00 to 0x2C
  task chk_defaults;
    chk({10'h0, app_lamp, fail_lamp, sysfail_drv, dcache_en, icache_en, parity_en,
      wd_halt, wd_run, ser2_en, ser4_en, boot2_en, rel_any, fair_req, req_level},
      32'h3FF013);
    chk({15'h0, vslave_cfg}, {15'h0, VSLAVE_RST});
    chk({13'h0, vintr_cfg}, {13'h0, VINTR_RST});
    chk(xlate_word, 32'h0);
    for (int i = 0; i < 12; i++) begin
      rd(ofs[i], dflt[i]);
    end
  endtask : chk_defaults
  // Main sequence
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(3);
    chk_defaults();
    rd(6'h3C, 32'h0);
    wr(OFS_IRQ_STAT, 32'h7);
    rd(OFS_IRQ_STAT, 32'h0);
    // Abort is live and unmaskable from reset
    i_brd_backplane.pulse(0);
    cyc(3);
    chk(irq, 32'h1);
    rd(OFS_IRQ_STAT, 32'h1);
    cyc(2);
    chk(irq, 32'h0);
    // Parity faults ignored while the checker is off
    i_brd_backplane.pulse(1);
    cyc(3);
    rd(OFS_IRQ_STAT, 32'h0);
    wr(OFS_MEM, 32'h1);
    cyc(1);
    chk(parity_en, 32'h1);
    i_brd_backplane.pulse(1);
    cyc(3);
    chk(irq, 32'h0);
    rd(OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_MASK, 32'h6);
    rd(OFS_IRQ_MASK, 32'h7);
    i_brd_backplane.pulse(1);
    cyc(3);
    chk(irq, 32'h1);
    rd(OFS_IRQ_STAT, 32'h2);
    // Failure line asserted but not received until enabled
    rd(OFS_IRQ_STAT, 32'h0);
    wr(OFS_SYSCTL, 32'h4);
    cyc(3);
    chk(irq, 32'h1);
    rd(OFS_IRQ_STAT, 32'h4);
    // Self test done: release failure line and lamps
    wr(OFS_SYSCTL, 32'h6);
    wr(OFS_LAMP, 32'h0);
    cyc(2);
    rd(OFS_IRQ_STAT, 32'h4);
    rd(OFS_IRQ_STAT, 32'h0);
    chk({app_lamp, fail_lamp, sysfail_drv}, 32'h0);
    // Another board still pulling the failure line is received
    i_brd_backplane.hold_fail(1'b1);
    cyc(3);
    chk(irq, 32'h1);
    rd(OFS_IRQ_STAT, 32'h4);
    i_brd_backplane.hold_fail(1'b0);
    // Invalidate before enabling, cache word only whole
    wr(OFS_CMD, 32'h1);
    cyc(2);
    chk(n_inv, 32'h1);
    wrb(OFS_CACHE, 32'h80008000, 4'h3);
    rd(OFS_CACHE, 32'h0);
    wr(OFS_CACHE, 32'h80008000);
    cyc(2);
    chk({dcache_en, icache_en}, 32'h3);
    wr(OFS_XLATE, 32'hFE01C040);
    cyc(2);
    chk(xlate_word, 32'hFE01C040);
    // Jumper overrides the request level
    jumper_fitted <= 1'b1;
    for (int lv = 0; lv < 4; lv++) begin
      jumper_level <= lv[1:0];
      cyc(3);
      chk(req_level, lv);
    end
    jumper_fitted <= 1'b0;
    jumper_level <= 2'h0;
    wr(OFS_VSLAVE, 32'h1FFFF);
    // Backplane reset restores every default
    i_brd_backplane.pulse(2);
    cyc(4);
    chk(n_rst, 32'h1);
    chk_defaults();
    // Ignore bit set: backplane reset has no effect
    wr(OFS_SYSCTL, 32'h1);
    i_brd_backplane.pulse(2);
    cyc(4);
    chk(n_rst, 32'h1);
    rd(OFS_SYSCTL, 32'h1);
    finish_test();
  end
endmodule : brd_defaults_bench
